// ---- include/comp_bias_pkg.sv ----
// shared constants, types and states for the compensation and bias link
`default_nettype none
package comp_bias_pkg;
    // command codes
    localparam logic [7:0] CMD_COMP = 8'hB1;
    localparam logic [7:0] CMD_BIAS = 8'hB5;
    localparam logic [7:0] CMD_OVR = 8'hEE;
    localparam logic [7:0] CMD_STORE = 8'h15;
    localparam logic [7:0] CMD_RESTORE = 8'h16;
    // block lengths in data bytes
    localparam logic [7:0] LEN_COMP = 8'h05;
    localparam logic [7:0] LEN_BIAS = 8'h01;
    localparam logic [7:0] LEN_OVR = 8'h01;
    localparam logic [7:0] LEN_NONE = 8'h00;
    // values after reset
    localparam logic [39:0] COMP_RST = 40'h00_0000_0000;
    localparam logic [7:0] BIAS_RST = 8'h90;
    localparam logic [7:0] OVR_RST = 8'h01;
    // compensation word layout
    localparam logic [39:0] COMP_RESV_MASK = 40'h00_0001_00CC;
    localparam int CZI_LO_LSB = 38;
    localparam int CPI_LSB = 33;
    localparam int CZI_MUL_BIT = 32;
    localparam int RVI_LSB = 26;
    localparam int CZI_HI_LSB = 24;
    localparam int CZV_LO_LSB = 22;
    localparam int CPV_LSB = 17;
    localparam int RVV_LSB = 10;
    localparam int CZV_HI_LSB = 8;
    localparam int GMV_LSB = 4;
    localparam int GMI_LSB = 0;
    // bias and override register layout
    localparam int BIAS_SEL_LSB = 4;
    localparam logic [3:0] BIAS_MIN = 4'h3;
    localparam logic [3:0] BIAS_MAX = 4'hA;
    localparam logic [3:0] BIAS_RESV_VAL = 4'h0;
    localparam int OVR_COMP_BIT = 0;
    // transaction time limit
    localparam real TXN_MAX_MS = 1.0;
    localparam real CLK_MHZ = 25.0;
    localparam int TXN_MAX_CYC = int'(TXN_MAX_MS * CLK_MHZ * 1000.0);
    // apb register offsets and fields
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_WLO = 8'h04;
    localparam logic [7:0] A_WHI = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_RLO = 8'h10;
    localparam logic [7:0] A_RHI = 8'h14;
    localparam int GO_BIT = 0;
    localparam int RNW_BIT = 1;
    localparam int LOWOK_BIT = 2;
    localparam int CMD_LSB = 8;
    localparam int CNT_LSB = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_REF = 3;

    typedef struct packed {
        logic [3:0] current_integ_cap_select;
        logic [4:0] current_filter_cap_select;
        logic current_integ_cap_doubler;
        logic [5:0] current_gain_res_select;
        logic [3:0] voltage_integ_cap_select;
        logic [4:0] voltage_filter_cap_select;
        logic [5:0] voltage_gain_res_select;
        logic [1:0] voltage_transcond_select;
        logic [1:0] current_transcond_select;
    } loop_sel_s;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_WR = 2'b01,
        D_FIN = 2'b11,
        D_RD = 2'b10
    } dev_state_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b11
    } host_state_e;
endpackage
`default_nettype wire

// ---- include/comp_bias_link_if.sv ----
// block transfer link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface comp_bias_link_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic start;
    logic rnw;
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [7:0] wbyte;
    logic wvalid;
    logic [7:0] rbyte;
    logic rvalid;
    logic done;
    logic err;

    modport dev (
        input pclk, presetn, start, rnw, cmd, cnt, wbyte, wvalid,
        output rbyte, rvalid, done, err
    );
    modport host (
        input pclk, presetn, rbyte, rvalid, done, err,
        output start, rnw, cmd, cnt, wbyte, wvalid
    );
endinterface
`default_nettype wire

// ---- hw/level_sync.sv ----
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- hw/comp_bias_device.sv ----
// device end: compensation and bias registers behind the block link
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module comp_bias_device #(
    parameter int unsigned TXN_LIMIT = comp_bias_pkg::TXN_MAX_CYC
) (
    // link to host
    comp_bias_link_if.dev lk,
    // device pins
    input wire logic conversion_enable,
    input wire logic analog_supply_ok,
    input wire logic [39:0] strap_comp,
    // control loop and bias regulator
    output comp_bias_pkg::loop_sel_s loop_settings,
    output logic [3:0] bias_level_select,
    output logic hw_update_blocked
);
    comp_bias_pkg::dev_state_e state_q;
    logic [7:0] cmd_q;
    logic [7:0] cnt_q;
    logic rnw_q;
    logic rd_ok_q;
    logic [7:0] idx_q;
    logic [31:0] wd_q;
    logic [39:0] buf_q;
    logic [39:0] rd_sh_q;
    logic [7:0] rd_len_q;
    logic [39:0] comp_q;
    logic [39:0] nvm_comp_q;
    logic [7:0] nvm_bias_q;
    logic [7:0] bias_q;
    logic [7:0] ovr_q;
    logic supply_d_q;
    logic conv_s;
    logic supply_s;
    logic [39:0] strap_s;
    logic [8:0] info;
    logic [8:0] info_in;
    logic timeout;
    logic bias_ok;
    logic wr_ok;
    logic restore;
    logic [39:0] restore_word;

    level_sync #(.W(42)) u_sync (
        .pclk(lk.pclk),
        .presetn(lk.presetn),
        .async_in({conversion_enable, analog_supply_ok, strap_comp}),
        .sync_out({conv_s, supply_s, strap_s})
    );

    // known flag and length of a command
    function automatic logic [8:0] cmd_info(input logic [7:0] c);
        case (c)
            comp_bias_pkg::CMD_COMP: cmd_info = {1'b1, comp_bias_pkg::LEN_COMP};
            comp_bias_pkg::CMD_BIAS: cmd_info = {1'b1, comp_bias_pkg::LEN_BIAS};
            comp_bias_pkg::CMD_OVR: cmd_info = {1'b1, comp_bias_pkg::LEN_OVR};
            comp_bias_pkg::CMD_STORE: cmd_info = {1'b1, comp_bias_pkg::LEN_NONE};
            comp_bias_pkg::CMD_RESTORE: cmd_info = {1'b1, comp_bias_pkg::LEN_NONE};
            default: cmd_info = {1'b0, comp_bias_pkg::LEN_NONE};
        endcase
    endfunction

    // split the packed word into loop selects
    function automatic comp_bias_pkg::loop_sel_s unpack(input logic [39:0] w);
        unpack.current_integ_cap_select = {w[comp_bias_pkg::CZI_HI_LSB +: 2],
            w[comp_bias_pkg::CZI_LO_LSB +: 2]};
        unpack.current_filter_cap_select = w[comp_bias_pkg::CPI_LSB +: 5];
        unpack.current_integ_cap_doubler = w[comp_bias_pkg::CZI_MUL_BIT];
        unpack.current_gain_res_select = w[comp_bias_pkg::RVI_LSB +: 6];
        unpack.voltage_integ_cap_select = {w[comp_bias_pkg::CZV_HI_LSB +: 2],
            w[comp_bias_pkg::CZV_LO_LSB +: 2]};
        unpack.voltage_filter_cap_select = w[comp_bias_pkg::CPV_LSB +: 5];
        unpack.voltage_gain_res_select = w[comp_bias_pkg::RVV_LSB +: 6];
        unpack.voltage_transcond_select = w[comp_bias_pkg::GMV_LSB +: 2];
        unpack.current_transcond_select = w[comp_bias_pkg::GMI_LSB +: 2];
    endfunction

    assign info = cmd_info(cmd_q);
    assign info_in = cmd_info(lk.cmd);
    assign timeout = (state_q == comp_bias_pkg::D_WR || state_q == comp_bias_pkg::D_RD)
        && wd_q == 32'(TXN_LIMIT - 1);
    assign bias_ok = buf_q[comp_bias_pkg::BIAS_SEL_LSB +: 4] >= comp_bias_pkg::BIAS_MIN
        && buf_q[comp_bias_pkg::BIAS_SEL_LSB +: 4] <= comp_bias_pkg::BIAS_MAX;
    assign wr_ok = info[8] && cnt_q == info[7:0]
        && (cmd_q != comp_bias_pkg::CMD_BIAS || bias_ok);
    assign restore = (state_q == comp_bias_pkg::D_FIN && !rnw_q && wr_ok
        && cmd_q == comp_bias_pkg::CMD_RESTORE) || (supply_s && !supply_d_q);
    assign restore_word = ovr_q[comp_bias_pkg::OVR_COMP_BIT] ? strap_s : nvm_comp_q;

    // transfer sequencing
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            state_q <= comp_bias_pkg::D_IDLE;
            cmd_q <= 8'h00;
            cnt_q <= 8'h00;
            rnw_q <= 1'b0;
            idx_q <= 8'h00;
            wd_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                comp_bias_pkg::D_IDLE: begin
                    idx_q <= 8'h00;
                    wd_q <= 32'h0000_0000;
                    if (lk.start) begin
                        cmd_q <= lk.cmd;
                        cnt_q <= lk.cnt;
                        rnw_q <= lk.rnw;
                        if (lk.rnw) begin
                            state_q <= comp_bias_pkg::D_RD;
                        end else if (lk.cnt == 8'h00) begin
                            state_q <= comp_bias_pkg::D_FIN;
                        end else begin
                            state_q <= comp_bias_pkg::D_WR;
                        end
                    end
                end
                comp_bias_pkg::D_WR: begin
                    wd_q <= wd_q + 32'h0000_0001;
                    if (timeout) begin
                        state_q <= comp_bias_pkg::D_IDLE;
                    end else if (lk.wvalid) begin
                        idx_q <= idx_q + 8'h01;
                        if (idx_q + 8'h01 == cnt_q) begin
                            state_q <= comp_bias_pkg::D_FIN;
                        end
                    end
                end
                comp_bias_pkg::D_RD: begin
                    wd_q <= wd_q + 32'h0000_0001;
                    idx_q <= idx_q + 8'h01;
                    if (timeout || !rd_ok_q || idx_q == rd_len_q) begin
                        state_q <= comp_bias_pkg::D_FIN;
                    end
                end
                comp_bias_pkg::D_FIN: state_q <= comp_bias_pkg::D_IDLE;
                default: state_q <= comp_bias_pkg::D_IDLE;
            endcase
        end
    end

    // write collection and read word
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            buf_q <= 40'h00_0000_0000;
            rd_sh_q <= 40'h00_0000_0000;
            rd_len_q <= 8'h00;
            rd_ok_q <= 1'b0;
        end else if (state_q == comp_bias_pkg::D_IDLE && lk.start) begin
            buf_q <= 40'h00_0000_0000;
            rd_len_q <= info_in[7:0];
            rd_ok_q <= info_in[8] && info_in[7:0] != 8'h00;
            case (lk.cmd)
                comp_bias_pkg::CMD_COMP: rd_sh_q <= comp_q;
                comp_bias_pkg::CMD_BIAS: rd_sh_q <= {32'h0000_0000, bias_q};
                comp_bias_pkg::CMD_OVR: rd_sh_q <= {32'h0000_0000, ovr_q};
                default: rd_sh_q <= 40'h00_0000_0000;
            endcase
        end else if (state_q == comp_bias_pkg::D_WR && lk.wvalid && idx_q < 8'h05) begin
            buf_q[{idx_q[2:0], 3'b000} +: 8] <= lk.wbyte;
        end else if (state_q == comp_bias_pkg::D_RD && idx_q != 8'h00) begin
            rd_sh_q <= {8'h00, rd_sh_q[39:8]};
        end
    end

    // link answer: count byte first, then data low byte first
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            lk.rbyte <= 8'h00;
            lk.rvalid <= 1'b0;
            lk.done <= 1'b0;
            lk.err <= 1'b0;
        end else begin
            lk.rvalid <= state_q == comp_bias_pkg::D_RD && rd_ok_q && !timeout;
            lk.rbyte <= (idx_q == 8'h00) ? rd_len_q : rd_sh_q[7:0];
            lk.done <= state_q == comp_bias_pkg::D_FIN || (timeout
                && state_q == comp_bias_pkg::D_WR);
            lk.err <= (state_q == comp_bias_pkg::D_FIN && (rnw_q ? (!rd_ok_q || timeout)
                : !wr_ok)) || (timeout && state_q == comp_bias_pkg::D_WR);
        end
    end

    // watch for the analog supply coming back
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            supply_d_q <= 1'b0;
        end else begin
            supply_d_q <= supply_s;
        end
    end

    // registers, nvm copy and loop hardware
    always_ff @(posedge lk.pclk or negedge lk.presetn) begin
        if (!lk.presetn) begin
            comp_q <= comp_bias_pkg::COMP_RST;
            nvm_comp_q <= comp_bias_pkg::COMP_RST;
            bias_q <= comp_bias_pkg::BIAS_RST;
            nvm_bias_q <= comp_bias_pkg::BIAS_RST;
            ovr_q <= comp_bias_pkg::OVR_RST;
            loop_settings <= '0;
            hw_update_blocked <= 1'b0;
        end else if (restore) begin
            comp_q <= restore_word;
            loop_settings <= unpack(restore_word);
            bias_q <= nvm_bias_q;
            hw_update_blocked <= 1'b0;
        end else if (state_q == comp_bias_pkg::D_FIN && !rnw_q && wr_ok) begin
            case (cmd_q)
                comp_bias_pkg::CMD_COMP: begin
                    comp_q <= buf_q;
                    if (conv_s) begin
                        hw_update_blocked <= 1'b1;
                    end else begin
                        loop_settings <= unpack(buf_q);
                        hw_update_blocked <= 1'b0;
                    end
                end
                comp_bias_pkg::CMD_BIAS: bias_q <= {buf_q[comp_bias_pkg::BIAS_SEL_LSB +: 4],
                    comp_bias_pkg::BIAS_RESV_VAL};
                comp_bias_pkg::CMD_OVR: ovr_q <= buf_q[7:0];
                comp_bias_pkg::CMD_STORE: begin
                    nvm_comp_q <= comp_q;
                    nvm_bias_q <= bias_q;
                end
                default: ovr_q <= ovr_q;
            endcase
        end
    end

    assign bias_level_select = bias_q[comp_bias_pkg::BIAS_SEL_LSB +: 4];
endmodule
`default_nettype wire

// ---- hw/comp_bias_host.sv ----
// host end: apb-programmed block transfer master for the link
`timescale 1ns/100ps
`default_nettype none
module comp_bias_host (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to device
    comp_bias_link_if.host lk
);
    comp_bias_pkg::host_state_e state_q;
    logic [23:0] ctrl_q;
    logic [39:0] wdata_q;
    logic [39:0] rdata_q;
    logic [7:0] rcount_q;
    logic [39:0] send_q;
    logic [7:0] idx_q;
    logic [7:0] rix_q;
    logic done_q;
    logic err_q;
    logic ref_q;
    logic acc;
    logic go;
    logic low_bias;

    function automatic logic hit(input logic [7:0] a);
        hit = a == comp_bias_pkg::A_CTRL || a == comp_bias_pkg::A_WLO
            || a == comp_bias_pkg::A_WHI || a == comp_bias_pkg::A_STAT
            || a == comp_bias_pkg::A_RLO || a == comp_bias_pkg::A_RHI;
    endfunction

    assign acc = psel && penable && pready;
    assign go = acc && pwrite && paddr == comp_bias_pkg::A_CTRL
        && pwdata[comp_bias_pkg::GO_BIT] && state_q == comp_bias_pkg::H_IDLE;
    assign low_bias = !pwdata[comp_bias_pkg::RNW_BIT]
        && pwdata[comp_bias_pkg::CMD_LSB +: 8] == comp_bias_pkg::CMD_BIAS
        && wdata_q[comp_bias_pkg::BIAS_SEL_LSB +: 4] == comp_bias_pkg::BIAS_MIN
        && !pwdata[comp_bias_pkg::LOWOK_BIT];

    // apb handshake with one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit(paddr);
            if (psel && !penable) begin
                case (paddr)
                    comp_bias_pkg::A_CTRL: prdata <= {8'h00, ctrl_q};
                    comp_bias_pkg::A_WLO: prdata <= wdata_q[31:0];
                    comp_bias_pkg::A_WHI: prdata <= {24'h00_0000, wdata_q[39:32]};
                    comp_bias_pkg::A_STAT: prdata <= {28'h000_0000, ref_q, err_q, done_q,
                        state_q != comp_bias_pkg::H_IDLE};
                    comp_bias_pkg::A_RLO: prdata <= rdata_q[31:0];
                    comp_bias_pkg::A_RHI: prdata <= {16'h0000, rcount_q, rdata_q[39:32]};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 24'h00_0000;
            wdata_q <= 40'h00_0000_0000;
        end else if (acc && pwrite) begin
            if (paddr == comp_bias_pkg::A_CTRL) begin
                ctrl_q <= {pwdata[23:1], 1'b0};
            end
            if (paddr == comp_bias_pkg::A_WLO) begin
                wdata_q[31:0] <= pwdata;
            end
            if (paddr == comp_bias_pkg::A_WHI) begin
                wdata_q[39:32] <= pwdata[7:0];
            end
        end
    end

    // status flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            if (state_q == comp_bias_pkg::H_WAIT && lk.done) begin
                done_q <= 1'b1;
                err_q <= lk.err;
            end else if (acc && pwrite && paddr == comp_bias_pkg::A_STAT) begin
                done_q <= done_q && !pwdata[comp_bias_pkg::ST_DONE];
                err_q <= err_q && !pwdata[comp_bias_pkg::ST_ERR];
            end
            if (go && low_bias) begin
                ref_q <= 1'b1;
            end else if (acc && pwrite && paddr == comp_bias_pkg::A_STAT) begin
                ref_q <= ref_q && !pwdata[comp_bias_pkg::ST_REF];
            end
        end
    end

    // link sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= comp_bias_pkg::H_IDLE;
            lk.start <= 1'b0;
            lk.rnw <= 1'b0;
            lk.cmd <= 8'h00;
            lk.cnt <= 8'h00;
            lk.wbyte <= 8'h00;
            lk.wvalid <= 1'b0;
            send_q <= 40'h00_0000_0000;
            idx_q <= 8'h00;
            rix_q <= 8'h00;
            rdata_q <= 40'h00_0000_0000;
            rcount_q <= 8'h00;
        end else begin
            lk.start <= 1'b0;
            lk.wvalid <= 1'b0;
            case (state_q)
                comp_bias_pkg::H_IDLE: begin
                    if (go && !low_bias) begin
                        lk.start <= 1'b1;
                        lk.rnw <= pwdata[comp_bias_pkg::RNW_BIT];
                        lk.cmd <= pwdata[comp_bias_pkg::CMD_LSB +: 8];
                        lk.cnt <= pwdata[comp_bias_pkg::CNT_LSB +: 8];
                        idx_q <= 8'h00;
                        rix_q <= 8'h00;
                        if (pwdata[comp_bias_pkg::CMD_LSB +: 8] == comp_bias_pkg::CMD_COMP) begin
                            send_q <= wdata_q & ~comp_bias_pkg::COMP_RESV_MASK;
                        end else begin
                            send_q <= wdata_q;
                        end
                        if (!pwdata[comp_bias_pkg::RNW_BIT]
                            && pwdata[comp_bias_pkg::CNT_LSB +: 8] != 8'h00) begin
                            state_q <= comp_bias_pkg::H_SEND;
                        end else begin
                            state_q <= comp_bias_pkg::H_WAIT;
                        end
                    end
                end
                comp_bias_pkg::H_SEND: begin
                    lk.wvalid <= 1'b1;
                    lk.wbyte <= send_q[7:0];
                    send_q <= {8'h00, send_q[39:8]};
                    idx_q <= idx_q + 8'h01;
                    if (idx_q + 8'h01 == lk.cnt) begin
                        state_q <= comp_bias_pkg::H_WAIT;
                    end
                end
                comp_bias_pkg::H_WAIT: begin
                    if (lk.rvalid) begin
                        rix_q <= rix_q + 8'h01;
                        if (rix_q == 8'h00) begin
                            rcount_q <= lk.rbyte;
                        end else if (rix_q < 8'h06) begin
                            rdata_q[{rix_q[2:0] - 3'b001, 3'b000} +: 8] <= lk.rbyte;
                        end
                    end
                    if (lk.done) begin
                        state_q <= comp_bias_pkg::H_IDLE;
                    end
                end
                default: state_q <= comp_bias_pkg::H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- test/comp_bias_asserts.sv ----
// link checker for the compensation and bias transfers
`timescale 1ns/100ps
`default_nettype none
module comp_bias_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // host to device
    input wire logic start,
    input wire logic rnw,
    input wire logic [7:0] cmd,
    input wire logic [7:0] cnt,
    input wire logic [7:0] wbyte,
    input wire logic wvalid,
    // device to host
    input wire logic [7:0] rbyte,
    input wire logic rvalid,
    input wire logic done,
    input wire logic err
);
    logic [2:0] wcnt_q;
    logic wr_b1, wr_b5, bad_code;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_b1 = wvalid && !rnw && cmd == comp_bias_pkg::CMD_COMP;
    assign wr_b5 = wvalid && !rnw && cmd == comp_bias_pkg::CMD_BIAS && cnt == 8'h01;
    assign bad_code = wbyte[7:4] < 4'h3 || wbyte[7:4] > 4'hA;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wcnt_q <= 3'h0;
        else if (start) wcnt_q <= 3'h0;
        else if (wvalid) wcnt_q <= wcnt_q + 3'h1;
    end
    a_done_bounded: assert property (start |-> ##[2:80] done)
        else $error("transfer not finished in time");
    a_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_comp_count: assert property (start && rnw && cmd == 8'hB1 |-> ##2 rvalid && rbyte == 8'h05)
        else $error("compensation read count wrong");
    a_bias_count: assert property (start && rnw && cmd == 8'hB5 |-> ##2 rvalid && rbyte == 8'h01)
        else $error("bias read count wrong");
    a_read_ends: assert property ($fell(rvalid) |-> done)
        else $error("read not closed after last byte");
    a_bias_refused: assert property (wr_b5 && bad_code |-> ##2 done && err)
        else $error("invalid bias code not refused");
    a_bias_taken: assert property (wr_b5 && !bad_code |-> ##2 done && !err)
        else $error("valid bias code refused");
    a_resv_low: assert property (wr_b1 && wcnt_q == 3'h0 |-> (wbyte & 8'hCC) == 8'h00)
        else $error("reserved low bits sent nonzero");
    a_resv_mid: assert property (wr_b1 && wcnt_q == 3'h2 |-> !wbyte[0])
        else $error("reserved bit 16 sent nonzero");
endmodule
`default_nettype wire

// ---- test/tb_compensation_and_bias_config.sv ----
// testbench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module tb_compensation_and_bias_config;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic conversion_enable = 1'b0, analog_supply_ok = 1'b0, pready, pslverr, hw_update_blocked;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] bias_level_select, cur;
    logic [39:0] w, v, strap_comp = 40'h0;
    logic [64:0] q[$];
    comp_bias_pkg::loop_sel_s loop_settings;
    int mismatches, comparisons;
    comp_bias_link_if lk (.pclk(pclk), .presetn(presetn));
    comp_bias_device #(.TXN_LIMIT(64)) comp_bias_device_i (.lk(lk.dev), .conversion_enable,
        .analog_supply_ok, .strap_comp, .loop_settings, .bias_level_select, .hw_update_blocked);
    comp_bias_host comp_bias_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lk(lk.host));
    comp_bias_asserts comp_bias_asserts_i (.pclk, .presetn, .start(lk.start), .rnw(lk.rnw),
        .cmd(lk.cmd), .cnt(lk.cnt), .wbyte(lk.wbyte), .wvalid(lk.wvalid), .rbyte(lk.rbyte),
        .rvalid(lk.rvalid), .done(lk.done), .err(lk.err));
    initial begin
        forever #20 pclk = ~pclk;
    end
    task automatic check(string n, logic [39:0] s, logic [39:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    function automatic comp_bias_pkg::loop_sel_s unpk(logic [39:0] d);
        return '{{d[25:24], d[39:38]}, d[37:33], d[32], d[31:26], {d[9:8], d[23:22]},
            d[21:17], d[15:10], d[5:4], d[1:0]};
    endfunction
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, logic er);
        q.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic go(logic [7:0] c, logic [7:0] n, logic r, logic [39:0] d);
        int k = 0;
        apb(1'b1, 8'h04, d[31:0]);
        apb(1'b1, 8'h08, {24'h0, d[39:32]});
        apb(1'b1, 8'h00, {8'h0, n, c, 5'h0, 1'b1, r, 1'b1});
        while (lk.done !== 1'b1 && k++ < 200) @(negedge pclk);
        repeat (3) @(negedge pclk);
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            check("prdata", {7'h0, pslverr, prdata & q[0][63:32]}, {7'h0, q[0][64], q[0][31:0]});
            void'(q.pop_front());
        end
    end
    initial begin
        void'($urandom(48));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check("bias", 40'(bias_level_select), 40'h9);
        rd(8'h20, 32'h0, '1, 1'b1);
        w = {8'($urandom), 32'($urandom)};
        go(8'hB1, 8'h05, 1'b0, w);
        check("loop", loop_settings, unpk(w));
        check("loop", loop_settings, unpk(w));
        w = w & ~comp_bias_pkg::COMP_RESV_MASK;
        go(8'hB1, 8'h00, 1'b1, 40'h0);
        rd(8'h10, w[31:0], '1, 1'b0);
        rd(8'h14, {16'h0, 8'h05, w[39:32]}, 32'hFFFF, 1'b0);
        conversion_enable <= 1'b1;
        v = {8'($urandom), 32'($urandom)};
        go(8'hB1, 8'h05, 1'b0, v);
        check("blocked", 40'(hw_update_blocked), 40'h1);
        check("loop", loop_settings, unpk(w));
        go(8'h15, 8'h00, 1'b0, 40'h0);
        go(8'hEE, 8'h01, 1'b0, 40'h0);
        go(8'h16, 8'h00, 1'b0, 40'h0);
        check("loop", loop_settings, unpk(v));
        go(8'hEE, 8'h01, 1'b0, 40'h1);
        @(posedge pclk);
        strap_comp <= w;
        analog_supply_ok <= 1'b1;
        repeat (6) @(negedge pclk);
        check("loop", loop_settings, unpk(w));
        cur = 4'h9;
        for (int i = 0; i < 16; i++) begin
            go(8'hB5, 8'h01, 1'b0, {32'h0, 4'(i), 4'($urandom)});
            if (i >= 3 && i <= 10) cur = 4'(i);
            check("bias", 40'(bias_level_select), 40'(cur));
        end
        go(8'hB5, 8'h00, 1'b1, 40'h0);
        rd(8'h14, 32'h100, 32'hFF00, 1'b0);
        rd(8'h10, 32'hA0, 32'hFF, 1'b0);
        apb(1'b1, 8'h04, 32'h30);
        apb(1'b1, 8'h00, 32'h0001_B501);
        rd(8'h0C, 32'h8, 32'h8, 1'b0);
        check("bias", 40'(bias_level_select), 40'(cur));
        repeat (4) @(posedge pclk);
        complete_run();
    end
    initial begin
        #2000000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
